//--- rtl/isr_pkg.sv
package isr_pkg;

  //////////////////////////////////////////////////////////////////////////////
  // abnormal-operation condition word, bit positions
  localparam int QB_OVER_VOLTAGE = 0;
  localparam int QB_OVER_CURRENT = 1;
  localparam int QB_POWER_FAIL = 2;
  localparam int QB_POWER_LIMIT = 3;
  localparam int QB_OVER_TEMP = 4;
  localparam int QB_MASTER_SLAVE = 5;
  localparam int QB_INHIBIT = 9;
  localparam int QB_UNREGULATED = 10;
  localparam logic [15:0] QUE_MASK = 16'h063f;

  // standard event bits
  localparam int EB_OPC = 0;
  localparam int EB_QUERY = 2;
  localparam int EB_DEVICE = 3;
  localparam int EB_EXEC = 4;
  localparam int EB_SYNTAX = 5;
  localparam int EB_POWER_ON = 7;
  localparam logic [7:0] ESR_MASK = 8'hbd;

  // summary byte bits
  localparam int SB_ERRQ = 2;
  localparam int SB_QUES = 3;
  localparam int SB_MAV = 4;
  localparam int SB_ESB = 5;
  localparam int SB_MSS = 6;
  localparam int SB_OPER = 7;
  localparam logic [7:0] SRE_MASK = 8'hbc;

  // reset values
  localparam logic [7:0] ESR_RST = 8'h80;
  localparam logic [7:0] ESE_RST = 8'h00;
  localparam logic [7:0] SRE_RST = 8'h00;
  localparam logic [15:0] QEN_RST = 16'h0000;
  localparam logic [15:0] QRISE_RST = 16'h063f;
  localparam logic [15:0] QFALL_RST = 16'h0000;

  // error codes, two's complement
  localparam logic [15:0] ERR_OVERFLOW = 16'hfea2;
  localparam logic [15:0] ERR_NONE = 16'h0000;

  //////////////////////////////////////////////////////////////////////////////
  typedef enum logic [3:0] {
    SEL_STB, SEL_ESR, SEL_ESE, SEL_SRE, SEL_QCOND, SEL_QEVENT,
    SEL_QENABLE, SEL_QRISE, SEL_QFALL, SEL_ERRQ, SEL_OUTQ
  } isr_sel_type;

  typedef struct packed {
    logic rd;
    logic wr;
    isr_sel_type sel;
    logic [15:0] data;
  } isr_req_type;

  typedef struct packed {
    logic overVoltageTrip;
    logic overCurrentTrip;
    logic powerFailTrip;
    logic powerLimit;
    logic overTemp;
    logic masterSlaveTrip;
    logic externalInhibitTrip;
    logic outputUnregulated;
  } isr_trip_type;

  typedef struct packed {
    logic opcDone;
    logic newCmdBeforeRead;
    logic inputBufFull;
    logic deviceErr;
    logic execErr;
    logic syntaxErr;
  } isr_evt_type;

endpackage : isr_pkg

//--- rtl/isr_mem.sv
// simple dual-port storage, registered read data
module isr_mem
  import isr_pkg::*;
#(
  parameter int WIDTH = 16,
  parameter int DEPTH = 8,
  parameter int AW = $clog2(DEPTH)
)
(
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic wrEn,
  input wire logic [AW-1:0] wrAddr,
  input wire logic [WIDTH-1:0] wrData,
  input wire logic rdEn,
  input wire logic [AW-1:0] rdAddr,
  output logic [WIDTH-1:0] rdData
);

  logic [WIDTH-1:0] store [DEPTH];
  logic [WIDTH-1:0] rdData_r;

  // array has no reset, keeps it mappable to ram
  always_ff @(posedge sys_clk)
  begin
    if (wrEn)
    begin
      store[wrAddr] <= wrData;
    end
  end

  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
      rdData_r <= '0;
    else if (rdEn)
      rdData_r <= store[rdAddr];
  end

  assign rdData = rdData_r;

endmodule : isr_mem

//--- rtl/isr_status_core.sv
// Summary of operation
// - enabled abnormal-operation event bits ORed into summary bit 3
// - condition bits 0..5: voltage, current, power-fail, power-limit, temperature, master/slave
// - condition bit 9 inhibit, bit 10 unregulated; other bits read zero
// - standard event register is read-only and clears on read
// - event bit 0 set when operation-complete point executed
// - event bit 2 on empty read, unread query, or both buffers full
// - event bits 3,4,5: device error, execution error, syntax error
// - event bit 7 set at power-up until read or cleared; bits 1,6 zero
// - summary bit 2 high while error queue holds any entry
// - summary bit 5 is OR of enabled standard event bits
// - summary bit 7 is enabled normal-operation summary
// - output queue is fifo; summary bit 4 while not empty
// - master summary is unlatched OR of enabled summary bits
// - status query returns master summary at bit 6, changes nothing
// - service request raises request line and latches request bit 6
// - serial poll returns latched request at bit 6 then clears it only
// - error queue is fifo; a read removes the oldest entry
// - overflow stores code -350 in newest slot instead of new entry
// - rise filter passes rising, fall filter falling, both all, none none
// - event bits latch, further events ignored while set
// - enable registers are host writable and readable
module isr_status_core
  import isr_pkg::*;
#(
  parameter int ERR_DEPTH = 8,
  parameter int OUT_DEPTH = 16
)
(
  input wire logic sys_clk,
  input wire logic resetn,
  input wire isr_req_type hostReq,
  input wire logic serialPoll,
  input wire logic statusClear,
  input wire isr_trip_type trips,
  input wire isr_evt_type events,
  input wire logic opSummary,
  input wire logic errPush,
  input wire logic [15:0] errCode,
  input wire logic msgPush,
  input wire logic [7:0] msgData,
  output logic msgReady,
  output logic [15:0] rdData,
  output logic rdValid,
  output logic [7:0] pollData,
  output logic pollValid,
  output logic serviceRequest
);

  localparam int EAW = $clog2(ERR_DEPTH);
  localparam int OAW = $clog2(OUT_DEPTH);

  //////////////////////////////////////////////////////////////////////////////
  // registers
  logic [15:0] queCond_r, queEvent_r, queEnable_r, queRise_r, queFall_r;
  logic [7:0] esr_r, ese_r, sre_r;
  logic mssPrev_r, rqs_r;
  logic [EAW-1:0] errWrPtr_r, errRdPtr_r;
  logic [EAW:0] errCount_r;
  logic [OAW-1:0] outWrPtr_r, outRdPtr_r;
  logic [OAW:0] outCount_r;
  logic outFull_r, msgReady_r;
  logic popD_r, popErr_r, popEmpty_r;
  logic [15:0] rdData_r;
  logic rdValid_r;
  logic [7:0] pollData_r;
  logic pollValid_r;

  //////////////////////////////////////////////////////////////////////////////
  // host request decode
  wire rdReq = hostReq.rd;
  wire wrReq = hostReq.wr;
  wire isEsrRd = rdReq && hostReq.sel == SEL_ESR;
  wire isQevRd = rdReq && hostReq.sel == SEL_QEVENT;
  wire isErrPop = rdReq && hostReq.sel == SEL_ERRQ;
  wire isOutPop = rdReq && hostReq.sel == SEL_OUTQ;
  wire isQueuePop = isErrPop || isOutPop;

  //////////////////////////////////////////////////////////////////////////////
  // abnormal-operation group: condition, filters, events
  logic [15:0] condNow;
  always_comb
  begin
    condNow = '0;
    condNow[QB_OVER_VOLTAGE] = trips.overVoltageTrip;
    condNow[QB_OVER_CURRENT] = trips.overCurrentTrip;
    condNow[QB_POWER_FAIL] = trips.powerFailTrip;
    condNow[QB_POWER_LIMIT] = trips.powerLimit;
    condNow[QB_OVER_TEMP] = trips.overTemp;
    condNow[QB_MASTER_SLAVE] = trips.masterSlaveTrip;
    condNow[QB_INHIBIT] = trips.externalInhibitTrip;
    condNow[QB_UNREGULATED] = trips.outputUnregulated;
  end

  // edges against last sampled condition; reset condition is all clear
  wire [15:0] condRise = condNow & ~queCond_r;
  wire [15:0] condFall = ~condNow & queCond_r;
  wire [15:0] queSet = ((condRise & queRise_r) | (condFall & queFall_r)) & QUE_MASK;
  // set beats the read-clear so no edge is lost
  wire [15:0] queEvent_nxt = ((isQevRd || statusClear) ? 16'h0000 : queEvent_r) | queSet;
  wire queSummary = |(queEvent_r & queEnable_r);

  //////////////////////////////////////////////////////////////////////////////
  // output queue state
  wire outEmpty = outCount_r == '0;
  wire outWrEn = msgPush && !outFull_r;
  wire outRdEn = isOutPop && !outEmpty;

  //////////////////////////////////////////////////////////////////////////////
  // standard event register
  logic [7:0] esrSet;
  always_comb
  begin
    esrSet = '0;
    esrSet[EB_OPC] = events.opcDone;
    esrSet[EB_QUERY] = (isOutPop && outEmpty) || events.newCmdBeforeRead
      || (events.inputBufFull && outFull_r);
    esrSet[EB_DEVICE] = events.deviceErr;
    esrSet[EB_EXEC] = events.execErr;
    esrSet[EB_SYNTAX] = events.syntaxErr;
  end
  // power-on bit only comes from the reset value; read or clear drops it
  wire [7:0] esr_nxt = (((isEsrRd || statusClear) ? 8'h00 : esr_r) | esrSet) & ESR_MASK;

  //////////////////////////////////////////////////////////////////////////////
  // error queue control
  wire errEmpty = errCount_r == '0;
  wire errFull = errCount_r == (EAW+1)'(ERR_DEPTH);
  wire errLast = errCount_r == (EAW+1)'(ERR_DEPTH - 1);
  // a full queue already ends in the overflow entry, so later pushes drop
  wire errWrEn = errPush && (!errFull || statusClear);
  wire errRdEn = isErrPop && !errEmpty && !statusClear;
  // a pop in the same cycle makes room, so that push is a plain entry
  wire [15:0] errWrData = (errLast && !errRdEn && !statusClear) ? ERR_OVERFLOW : errCode;
  wire [EAW-1:0] errRdPtr_nxt = statusClear ? errWrPtr_r : errRdPtr_r + EAW'(errRdEn);
  wire [EAW:0] errCount_nxt = statusClear ? (EAW+1)'(errWrEn)
    : errCount_r + (EAW+1)'(errWrEn) - (EAW+1)'(errRdEn);
  wire [OAW:0] outCount_nxt = outCount_r + (OAW+1)'(outWrEn) - (OAW+1)'(outRdEn);

  //////////////////////////////////////////////////////////////////////////////
  // summary byte and service request
  wire [7:0] stbBase = {opSummary, 1'b0, |(esr_r & ese_r), !outEmpty,
    queSummary, !errEmpty, 2'b00};
  wire mss = |(stbBase & sre_r & SRE_MASK);
  wire rqsSet = mss && !mssPrev_r;
  // a new request in the poll cycle survives the poll
  wire rqs_nxt = rqsSet || (rqs_r && !serialPoll);
  wire [7:0] stbQuery = stbBase | (mss ? 8'h40 : 8'h00);
  wire [7:0] pollByte = stbBase | (rqs_r ? 8'h40 : 8'h00);

  //////////////////////////////////////////////////////////////////////////////
  // read data selection
  wire [15:0] popData;
  wire [15:0] errRdData;
  wire [7:0] outRdData;
  wire [15:0] regData =
    hostReq.sel == SEL_STB ? {8'h00, stbQuery} :
    hostReq.sel == SEL_ESR ? {8'h00, esr_r} :
    hostReq.sel == SEL_ESE ? {8'h00, ese_r} :
    hostReq.sel == SEL_SRE ? {8'h00, sre_r} :
    hostReq.sel == SEL_QCOND ? queCond_r :
    hostReq.sel == SEL_QEVENT ? queEvent_r :
    hostReq.sel == SEL_QENABLE ? queEnable_r :
    hostReq.sel == SEL_QRISE ? queRise_r :
    hostReq.sel == SEL_QFALL ? queFall_r : 16'h0000;
  assign popData = popEmpty_r ? ERR_NONE : (popErr_r ? errRdData : {8'h00, outRdData});
  wire [15:0] rdData_nxt = popD_r ? popData : regData;
  wire rdValid_nxt = (rdReq && !isQueuePop) || popD_r;

  //////////////////////////////////////////////////////////////////////////////
  // storage
  isr_mem #(.WIDTH(16), .DEPTH(ERR_DEPTH)) errMem (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .wrEn(errWrEn),
    .wrAddr(errWrPtr_r),
    .wrData(errWrData),
    .rdEn(errRdEn),
    .rdAddr(errRdPtr_r),
    .rdData(errRdData)
  );

  isr_mem #(.WIDTH(8), .DEPTH(OUT_DEPTH)) outMem (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .wrEn(outWrEn),
    .wrAddr(outWrPtr_r),
    .wrData(msgData),
    .rdEn(outRdEn),
    .rdAddr(outRdPtr_r),
    .rdData(outRdData)
  );

  //////////////////////////////////////////////////////////////////////////////
  // status and mask registers
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      queCond_r <= '0;
      queEvent_r <= '0;
      esr_r <= ESR_RST;
      mssPrev_r <= 1'b0;
      rqs_r <= 1'b0;
    end
    else
    begin
      queCond_r <= condNow;
      queEvent_r <= queEvent_nxt;
      esr_r <= esr_nxt;
      mssPrev_r <= mss;
      rqs_r <= rqs_nxt;
    end
  end

  // host-written masks
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      ese_r <= ESE_RST;
      sre_r <= SRE_RST;
      queEnable_r <= QEN_RST;
      queRise_r <= QRISE_RST;
      queFall_r <= QFALL_RST;
    end
    else if (wrReq)
    begin
      if (hostReq.sel == SEL_ESE) ese_r <= hostReq.data[7:0];
      if (hostReq.sel == SEL_SRE) sre_r <= hostReq.data[7:0] & SRE_MASK;
      if (hostReq.sel == SEL_QENABLE) queEnable_r <= hostReq.data & QUE_MASK;
      if (hostReq.sel == SEL_QRISE) queRise_r <= hostReq.data & QUE_MASK;
      if (hostReq.sel == SEL_QFALL) queFall_r <= hostReq.data & QUE_MASK;
    end
  end

  // queue pointers; depths must be powers of two for natural wrap
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      errWrPtr_r <= '0;
      errRdPtr_r <= '0;
      errCount_r <= '0;
      outWrPtr_r <= '0;
      outRdPtr_r <= '0;
      outCount_r <= '0;
      outFull_r <= 1'b0;
      msgReady_r <= 1'b1;
    end
    else
    begin
      errWrPtr_r <= errWrPtr_r + EAW'(errWrEn);
      errRdPtr_r <= errRdPtr_nxt;
      errCount_r <= errCount_nxt;
      outWrPtr_r <= outWrPtr_r + OAW'(outWrEn);
      outRdPtr_r <= outRdPtr_r + OAW'(outRdEn);
      outCount_r <= outCount_nxt;
      outFull_r <= outCount_nxt == (OAW+1)'(OUT_DEPTH);
      msgReady_r <= outCount_nxt != (OAW+1)'(OUT_DEPTH);
    end
  end

  // answers to the host
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      popD_r <= 1'b0;
      popErr_r <= 1'b0;
      popEmpty_r <= 1'b0;
      rdData_r <= '0;
      rdValid_r <= 1'b0;
      pollData_r <= '0;
      pollValid_r <= 1'b0;
    end
    else
    begin
      popD_r <= isQueuePop;
      popErr_r <= isErrPop;
      popEmpty_r <= isErrPop ? (errEmpty || statusClear) : outEmpty;
      rdData_r <= rdData_nxt;
      rdValid_r <= rdValid_nxt;
      pollData_r <= serialPoll ? pollByte : pollData_r;
      pollValid_r <= serialPoll;
    end
  end

  assign msgReady = msgReady_r;
  assign rdData = rdData_r;
  assign rdValid = rdValid_r;
  assign pollData = pollData_r;
  assign pollValid = pollValid_r;
  assign serviceRequest = rqs_r;

  //////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);

  sequence pollReq;
    serialPoll && !rqsSet;
  endsequence
  sequence pollDone;
    pollValid && !serviceRequest;
  endsequence

  request_raise_a: assert property (rqsSet |=> serviceRequest)
    else $error("service request not raised on rising summary");
  poll_clear_a: assert property (pollReq |=> pollDone)
    else $error("serial poll did not clear request");
  poll_bit6_a: assert property (serialPoll |=> pollData[SB_MSS] == $past(rqs_r))
    else $error("serial poll bit 6 wrong");
  esr_readclr_a: assert property ((isEsrRd && esrSet == 8'h00) |=> esr_r == 8'h00 && rdData == $past(esr_r))
    else $error("event register not cleared by read");
  pon_hold_a: assert property ($fell(esr_r[EB_POWER_ON]) |-> $past(isEsrRd || statusClear))
    else $error("power-on bit lost without read");
  errq_empty_a: assert property ((errCount_r == 1 && errRdEn && !errWrEn) |=> !stbBase[SB_ERRQ])
    else $error("error bit stays after last entry read");
  overflow_a: assert property ((errPush && errLast && !errRdEn && !statusClear) |=>
    errFull && $past(errWrData) == ERR_OVERFLOW)
    else $error("overflow entry not stored in last slot");
  mav_a: assert property ((outWrEn && outEmpty) |=> stbBase[SB_MAV])
    else $error("message available not shown");
  filter_a: assert property ((|queSet) |=> (queEvent_r & $past(queSet)) == $past(queSet))
    else $error("qualified transition not latched");
  query_still_a: assert property ((rdReq && hostReq.sel == SEL_STB && !rqsSet && !serialPoll) |=>
    rqs_r == $past(rqs_r))
    else $error("status query disturbed request bit");
  que_summary_a: assert property ($rose(queSummary) |-> ##[0:2] stbQuery[SB_QUES])
    else $error("abnormal summary bit missing");

endmodule : isr_status_core

//--- sim/isr_remote_ctl.sv
// remote bus controller: register queries and serial polls
module isr_remote_ctl
  import isr_pkg::*;
(
  input wire logic sys_clk,
  output isr_req_type hostReq,
  output logic serialPoll
);
  timeunit 1ns;
  timeprecision 100ps;

  ////////////////////////////////////////////////////////////////////////////
  // bus idle from time zero
  initial
  begin
    hostReq = '0;
    serialPoll = 1'b0;
  end

  // one access, then a spare cycle so queue-pop answers never collide
  task automatic access(input logic isRd, input isr_sel_type sel, input logic [15:0] data);
    @(posedge sys_clk);
    #1;
    hostReq = '{rd: isRd, wr: !isRd, sel: sel, data: data};
    @(posedge sys_clk);
    #1;
    hostReq = '{rd: 1'b0, wr: 1'b0, sel: sel, data: ~data}; // stale data is not left on the bus
    @(posedge sys_clk);
    #1;
  endtask : access

  // single-cycle poll; the answer carries the latch and then drops it
  task automatic poll();
    @(posedge sys_clk);
    #1;
    serialPoll = 1'b1;
    @(posedge sys_clk);
    #1;
    serialPoll = 1'b0;
  endtask : poll
endmodule : isr_remote_ctl

//--- sim/testbench.sv
module testbench;
  import isr_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int ERR_D = 4;
  localparam int OUT_D = 4;
  logic sys_clk = 1'b0;
  logic resetn = 1'b0;
  logic statusClear = 1'b0;
  isr_req_type hostReq;
  logic serialPoll;
  isr_trip_type trips = '0;
  isr_evt_type events = '0;
  logic opSummary = 1'b0;
  logic errPush = 1'b0;
  logic [15:0] errCode = 16'h0000;
  logic msgPush = 1'b0;
  logic [7:0] msgData = 8'h00;
  logic msgReady, rdValid, pollValid, serviceRequest;
  logic [15:0] rdData;
  logic [7:0] pollData;
  logic [15:0] expRd[$];
  logic [7:0] expPoll[$];
  logic [15:0] codes[$];
  logic [15:0] cond;
  integer seed = 32'h33babe39;
  int n_errors = 0;
  int checks_done = 0;

  ////////////////////////////////////////////////////////////////////////////
  // 125 MHz clock
  always #4 sys_clk = ~sys_clk;

  // small queue depths keep the overflow and refusal cases short
  isr_status_core #(.ERR_DEPTH(ERR_D), .OUT_DEPTH(OUT_D)) dut (
    .sys_clk(sys_clk), .resetn(resetn), .hostReq(hostReq), .serialPoll(serialPoll),
    .statusClear(statusClear), .trips(trips), .events(events), .opSummary(opSummary),
    .errPush(errPush), .errCode(errCode), .msgPush(msgPush), .msgData(msgData),
    .msgReady(msgReady), .rdData(rdData), .rdValid(rdValid), .pollData(pollData),
    .pollValid(pollValid), .serviceRequest(serviceRequest));

  isr_remote_ctl ctl (.sys_clk(sys_clk), .hostReq(hostReq), .serialPoll(serialPoll));

  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    checks_done++;
    if (got !== exp)
    begin
      $display("unexpected %s expected %h seen %h", what, exp, got);
      n_errors++;
    end
  endtask : check

  task automatic rd(input isr_sel_type sel, input logic [15:0] exp);
    expRd.push_back(exp);
    ctl.access(1'b1, sel, 16'h0000);
  endtask : rd

  task automatic wr(input isr_sel_type sel, input logic [15:0] data);
    ctl.access(1'b0, sel, data);
  endtask : wr

  task automatic poll(input logic [7:0] exp);
    expPoll.push_back(exp);
    ctl.poll();
  endtask : poll

  task automatic cycles(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask : cycles

  task automatic do_reset();
    resetn = 1'b0;
    cycles(8);
    resetn = 1'b1;
  endtask : do_reset

  task automatic print_verdict();
    if (n_errors == 0 && checks_done > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : print_verdict

  // answers are matched to the oldest note, sampled mid-cycle away from the edge
  always @(negedge sys_clk)
  begin
    if (rdValid === 1'b1)
    begin
      if (expRd.size() == 0)
        check("rdValid", 16'h0000, 16'h0001);
      else
        check("rdData", expRd.pop_front(), rdData);
    end
    if (pollValid === 1'b1)
    begin
      if (expPoll.size() == 0)
        check("pollValid", 16'h0000, 16'h0001);
      else
        check("pollData", {8'h00, expPoll.pop_front()}, {8'h00, pollData});
    end
  end

  // hang guard
  initial
  begin
    repeat (20000) @(posedge sys_clk);
    check("timeout", 16'h0000, 16'h0001);
    print_verdict();
  end

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    do_reset();
    // reset values, clear on read, writes to the event register ignored
    rd(SEL_ESR, 16'h0080);
    rd(SEL_ESR, 16'h0000);
    wr(SEL_ESR, 16'h00ff);
    rd(SEL_ESR, 16'h0000);
    rd(SEL_QRISE, 16'h063f);
    rd(SEL_STB, 16'h0000);
    // condition word, both filters, summary bit 3
    wr(SEL_QENABLE, 16'hffff);
    rd(SEL_QENABLE, 16'h063f);
    trips = isr_trip_type'(8'($random(seed)) | 8'h80);
    cond = {5'h00, trips.outputUnregulated, trips.externalInhibitTrip, 3'h0, trips.masterSlaveTrip,
      trips.overTemp, trips.powerLimit, trips.powerFailTrip, trips.overCurrentTrip, trips.overVoltageTrip};
    cycles(4);
    rd(SEL_STB, 16'h0008);
    rd(SEL_QCOND, cond);
    rd(SEL_QEVENT, cond);
    rd(SEL_QEVENT, 16'h0000);
    rd(SEL_STB, 16'h0000);
    wr(SEL_QRISE, 16'h0000);
    wr(SEL_QFALL, 16'h063f);
    rd(SEL_QFALL, 16'h063f);
    trips = '0;
    cycles(4);
    rd(SEL_QEVENT, cond);
    // every standard event source except input-buffer-full, bits 1 and 6 stay clear
    events = isr_evt_type'(6'h37);
    cycles(1);
    events = '0;
    rd(SEL_ESR, 16'h003d);
    rd(SEL_OUTQ, 16'h0000);
    rd(SEL_ESR, 16'h0004);
    // service request from the event summary; a poll drops only the latch
    wr(SEL_ESE, 16'h00ff);
    wr(SEL_SRE, 16'h0020);
    events = isr_evt_type'(6'h01);
    cycles(1);
    events = '0;
    cycles(2);
    check("serviceRequest", 16'h0001, {15'h0000, serviceRequest});
    rd(SEL_STB, 16'h0060);
    poll(8'h60);
    poll(8'h20);
    check("serviceRequest", 16'h0000, {15'h0000, serviceRequest});
    rd(SEL_STB, 16'h0060);
    rd(SEL_ESR, 16'h0020);
    rd(SEL_STB, 16'h0000);
    // operation summary routed through the service mask
    wr(SEL_SRE, 16'h0080);
    opSummary = 1'b1;
    cycles(3);
    check("serviceRequest", 16'h0001, {15'h0000, serviceRequest});
    rd(SEL_STB, 16'h00c0);
    opSummary = 1'b0;
    // error queue past full, after a second reset in mid-run
    do_reset();
    for (int i = 0; i < ERR_D + 1; i++)
    begin
      errCode = 16'($random(seed));
      if (i < ERR_D - 1)
        codes.push_back(errCode);
      errPush = 1'b1;
      cycles(1);
      errPush = 1'b0;
      cycles(1);
    end
    codes.push_back(ERR_OVERFLOW);
    codes.push_back(ERR_NONE);
    rd(SEL_STB, 16'h0004);
    while (codes.size() > 0)
      rd(SEL_ERRQ, codes.pop_front());
    rd(SEL_STB, 16'h0000);
    // output queue filled until refused, then drained in order
    for (int i = 0; i < 8 && msgReady === 1'b1; i++)
    begin
      msgData = 8'($random(seed));
      codes.push_back({8'h00, msgData});
      msgPush = 1'b1;
      cycles(1);
      msgPush = 1'b0;
      cycles(1);
    end
    check("msgCount", 16'(OUT_D), 16'(codes.size()));
    check("msgReady", 16'h0000, {15'h0000, msgReady});
    // input buffer full while the output queue is full
    events = isr_evt_type'(6'h08);
    cycles(1);
    events = '0;
    rd(SEL_ESR, 16'h0084);
    rd(SEL_STB, 16'h0010);
    while (codes.size() > 0)
      rd(SEL_OUTQ, codes.pop_front());
    rd(SEL_STB, 16'h0000);
    // clear-status empties the error queue and the event register
    errPush = 1'b1;
    events = isr_evt_type'(6'h02);
    cycles(1);
    errPush = 1'b0;
    events = '0;
    statusClear = 1'b1;
    cycles(1);
    statusClear = 1'b0;
    rd(SEL_STB, 16'h0000);
    rd(SEL_ESR, 16'h0000);
    rd(SEL_ERRQ, ERR_NONE);
    for (int i = 0; i < 20 && (expRd.size() + expPoll.size()) > 0; i++)
      cycles(1);
    check("pending", 16'h0000, 16'(expRd.size() + expPoll.size()));
    print_verdict();
  end
endmodule : testbench
